// [mssf_pkg.sv]
// constants for the ramp-rate configuration and fault status registers
// assumes one 250 MHz clock and a byte-wide register port from the host interface
package mssf_pkg;
  localparam logic [7:0] MSSF_OFS_SLEW_CFG = 8'h00a8;
  localparam logic [7:0] MSSF_OFS_FAULT_STAT = 8'h00a9;
  localparam logic [7:0] MSSF_RST_VAL = 8'h0000;
  localparam int MSSF_RATE2_LSB = 3;
  localparam int MSSF_RATE2_MSB = 5;
  localparam int MSSF_RATE1_LSB = 0;
  localparam int MSSF_RATE1_MSB = 2;
  localparam int MSSF_BIT_TARGET = 6;
  localparam int MSSF_BIT_CKSUM = 5;
  localparam int MSSF_BIT_FRAME = 4;
  localparam int MSSF_BIT_HOSTERR = 3;
  localparam int MSSF_BIT_HEAT = 2;
  localparam int MSSF_BIT_SUPV = 1;
  localparam int MSSF_BIT_DRVEN = 0;
  localparam int MSSF_BIT_SPARE = 7;
  localparam logic [7:0] MSSF_FLAG_MASK = 8'h007e;
  localparam int MSSF_CLK_PERIOD_NS = 4;
  // voltage step the sense input must ramp across before a monitor decision
  localparam longint MSSF_SENSE_STEP_UV = 100000;
  localparam int MSSF_DLY_W = 18;
  typedef logic [2:0] mssf_rate_t;
  typedef logic [MSSF_DLY_W-1:0] mssf_dly_t;

  // ramp rate in uV/us, code 0 fastest
  function automatic longint mssf_rate_uv_per_us(input mssf_rate_t code);
    case (code)
      3'h0: mssf_rate_uv_per_us = 33000;
      3'h1: mssf_rate_uv_per_us = 20000;
      3'h2: mssf_rate_uv_per_us = 10000;
      3'h3: mssf_rate_uv_per_us = 5000;
      3'h4: mssf_rate_uv_per_us = 2500;
      3'h5: mssf_rate_uv_per_us = 1300;
      3'h6: mssf_rate_uv_per_us = 630;
      default: mssf_rate_uv_per_us = 310;
    endcase
  endfunction : mssf_rate_uv_per_us

  // monitoring delay in clock cycles, rounded up, never below one
  function automatic mssf_dly_t mssf_delay_cycles(input mssf_rate_t code);
    longint ns;
    longint cyc;
    ns = (MSSF_SENSE_STEP_UV * 1000 + mssf_rate_uv_per_us(code) - 1) / mssf_rate_uv_per_us(code);
    cyc = (ns + MSSF_CLK_PERIOD_NS - 1) / MSSF_CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    mssf_delay_cycles = cyc[MSSF_DLY_W-1:0];
  endfunction : mssf_delay_cycles
endpackage : mssf_pkg

// [mssf_ramp_delay.sv]
// converts one sense input's ramp-rate code into its monitoring delay
// assumes the code comes from a configuration register in the same clock domain
`timescale 1ns/10ps
module mssf_ramp_delay (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire mssf_pkg::mssf_rate_t rate_code_i,
  output mssf_pkg::mssf_dly_t delay_o
);
  import mssf_pkg::*;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      delay_o <= '0;
    end else begin
      delay_o <= mssf_delay_cycles(rate_code_i); // see RL3
    end
  end
endmodule : mssf_ramp_delay

// [mssf_regs.sv]
// ramp-rate configuration and latched host-link fault status registers
// assumes the host interface decodes frames and presents byte accesses with
// one-cycle strobes; fault events arrive as synchronous one-cycle pulses
//
// How it works
// RL1 - bits 5:3 select second input's ramp rate
// RL2 - bits 2:0 select first input's ramp rate
// RL3 - monitoring delay derived from each ramp code
// RL4 - bit 6 latches bad target access
// RL5 - bit 5 latches checksum mismatch
// RL6 - target and checksum flags need checksum enable
// RL7 - target and checksum flags ignore masks
// RL8 - bit 4 latches malformed frame
// RL9 - bit 3 latches host error-signal fault
// RL10 - bit 2 latches overheat, independent of live
// RL11 - bit 1 clears only when supervisor events clear
// RL12 - writing one clears flags 6 to 1
// RL13 - bit 0 shows drive-enable pin level
// RL14 - writing zero leaves flags; flags stay set
`timescale 1ns/10ps
module mssf_regs (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic host_link_checksum_enable_i,
  input wire logic bad_target_evt_i,
  input wire logic checksum_fail_evt_i,
  input wire logic framing_fail_evt_i,
  input wire logic host_error_signal_fault_evt_i,
  input wire logic overheat_live_status_i,
  input wire logic supervisor_fault_evt_i,
  input wire logic supervisor_reset_event_i,
  input wire logic supervisor_fail_event_i,
  input wire logic supervisor_long_window_expiry_i,
  input wire logic drive_enable_output_i,
  output mssf_pkg::mssf_dly_t sense1_delay_o,
  output mssf_pkg::mssf_dly_t sense2_delay_o
);
  import mssf_pkg::*;

  logic [7:0] slew_cfg;
  logic [7:0] fault_stat;
  logic heat_prev;
  logic wr_cfg;
  logic wr_stat;
  logic supv_idle;
  logic [7:0] clr;
  logic [7:0] set;
  logic [7:0] next_fault_stat;

  assign wr_cfg = reg_wr_i && (reg_addr_i == MSSF_OFS_SLEW_CFG);
  assign wr_stat = reg_wr_i && (reg_addr_i == MSSF_OFS_FAULT_STAT);
  assign supv_idle = !supervisor_reset_event_i && !supervisor_fail_event_i
                     && !supervisor_long_window_expiry_i;

  // configuration: all eight bits are writable, spare bits included
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      slew_cfg <= MSSF_RST_VAL;
    end else if (wr_cfg) begin
      slew_cfg <= reg_wdata_i; // see RL1 see RL2
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      heat_prev <= 1'b0;
    end else begin
      heat_prev <= overheat_live_status_i;
    end
  end

  always_comb begin
    set = '0;
    // no mask is consulted for these two flags
    set[MSSF_BIT_TARGET] = bad_target_evt_i && host_link_checksum_enable_i; // see RL4 see RL6 see RL7
    set[MSSF_BIT_CKSUM] = checksum_fail_evt_i && host_link_checksum_enable_i; // see RL5 see RL6
    set[MSSF_BIT_FRAME] = framing_fail_evt_i; // see RL8
    set[MSSF_BIT_HOSTERR] = host_error_signal_fault_evt_i; // see RL9
    set[MSSF_BIT_HEAT] = overheat_live_status_i && !heat_prev; // see RL10
    set[MSSF_BIT_SUPV] = supervisor_fault_evt_i;
    clr = wr_stat ? (reg_wdata_i & MSSF_FLAG_MASK) : '0; // see RL12 see RL14
    clr[MSSF_BIT_SUPV] = clr[MSSF_BIT_SUPV] && supv_idle; // see RL11
    // set beats a clear in the same cycle
    next_fault_stat = ((fault_stat & ~clr) | set) & MSSF_FLAG_MASK;
    next_fault_stat[MSSF_BIT_SPARE] = wr_stat ? reg_wdata_i[MSSF_BIT_SPARE]
                                               : fault_stat[MSSF_BIT_SPARE];
    next_fault_stat[MSSF_BIT_DRVEN] = drive_enable_output_i; // see RL13
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_stat <= MSSF_RST_VAL;
    end else begin
      fault_stat <= next_fault_stat; // see RL14
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= MSSF_RST_VAL;
    end else if (reg_rd_i) begin
      if (reg_addr_i == MSSF_OFS_SLEW_CFG) begin
        reg_rdata_o <= slew_cfg;
      end else if (reg_addr_i == MSSF_OFS_FAULT_STAT) begin
        reg_rdata_o <= fault_stat;
      end else begin
        reg_rdata_o <= MSSF_RST_VAL;
      end
    end
  end

  mssf_ramp_delay u_sense1 (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .rate_code_i(slew_cfg[MSSF_RATE1_MSB:MSSF_RATE1_LSB]),
    .delay_o(sense1_delay_o)
  );

  mssf_ramp_delay u_sense2 (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .rate_code_i(slew_cfg[MSSF_RATE2_MSB:MSSF_RATE2_LSB]),
    .delay_o(sense2_delay_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // the write data has moved on by the time the delay settles, so look two cycles back
  property p_rate2_delay;
    wr_cfg |-> ##2 sense2_delay_o
      == mssf_delay_cycles($past(reg_wdata_i[MSSF_RATE2_MSB:MSSF_RATE2_LSB], 2));
  endproperty
  a_rate2_delay: assert property (p_rate2_delay) else $error("sense2 delay wrong"); // see RL1

  property p_rate1_delay;
    wr_cfg |-> ##2 sense1_delay_o
      == mssf_delay_cycles($past(reg_wdata_i[MSSF_RATE1_MSB:MSSF_RATE1_LSB], 2));
  endproperty
  a_rate1_delay: assert property (p_rate1_delay) else $error("sense1 delay wrong"); // see RL3

  property p_target_set;
    bad_target_evt_i && host_link_checksum_enable_i |=> fault_stat[MSSF_BIT_TARGET];
  endproperty
  a_target_set: assert property (p_target_set) else $error("bad target not latched"); // see RL4

  property p_cksum_gate;
    !fault_stat[MSSF_BIT_CKSUM] && !host_link_checksum_enable_i |=> !fault_stat[MSSF_BIT_CKSUM];
  endproperty
  a_cksum_gate: assert property (p_cksum_gate) else $error("checksum flag set while disabled"); // see RL6

  property p_cksum_set;
    checksum_fail_evt_i && host_link_checksum_enable_i |=> fault_stat[MSSF_BIT_CKSUM];
  endproperty
  a_cksum_set: assert property (p_cksum_set) else $error("checksum fail not latched"); // see RL5

  property p_frame_set;
    framing_fail_evt_i ##1 !framing_fail_evt_i && !wr_stat |=> fault_stat[MSSF_BIT_FRAME];
  endproperty
  a_frame_set: assert property (p_frame_set) else $error("frame flag lost"); // see RL8

  property p_hosterr_set;
    host_error_signal_fault_evt_i |=> fault_stat[MSSF_BIT_HOSTERR];
  endproperty
  a_hosterr_set: assert property (p_hosterr_set) else $error("host error not latched"); // see RL9

  property p_heat_rise;
    $rose(overheat_live_status_i) |=> fault_stat[MSSF_BIT_HEAT];
  endproperty
  a_heat_rise: assert property (p_heat_rise) else $error("overheat not latched"); // see RL10

  property p_supv_hold;
    fault_stat[MSSF_BIT_SUPV] && !supv_idle |=> fault_stat[MSSF_BIT_SUPV];
  endproperty
  a_supv_hold: assert property (p_supv_hold) else $error("supervisor flag cleared early"); // see RL11

  property p_w1c;
    wr_stat && reg_wdata_i[MSSF_BIT_FRAME] && !framing_fail_evt_i |=> !fault_stat[MSSF_BIT_FRAME];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear"); // see RL12

  property p_pin_read;
    reg_rd_i && reg_addr_i == MSSF_OFS_FAULT_STAT |=>
      reg_rdata_o[MSSF_BIT_DRVEN] == $past(drive_enable_output_i, 2);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin level misread"); // see RL13

  property p_flags_hold;
    !wr_stat |=> (fault_stat & MSSF_FLAG_MASK & $past(fault_stat)) == ($past(fault_stat) & MSSF_FLAG_MASK);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flag dropped without clear"); // see RL14

  property p_cfg_store;
    wr_cfg |=> slew_cfg == $past(reg_wdata_i);
  endproperty
  a_cfg_store: assert property (p_cfg_store) else $error("config write lost"); // see RL2

  property p_cfg_read;
    reg_rd_i && reg_addr_i == MSSF_OFS_SLEW_CFG |=> reg_rdata_o == $past(slew_cfg);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong"); // see RL1

  property p_target_gate;
    !fault_stat[MSSF_BIT_TARGET] && !host_link_checksum_enable_i
      |=> !fault_stat[MSSF_BIT_TARGET];
  endproperty
  a_target_gate: assert property (p_target_gate) else $error("target flag set while disabled"); // see RL6

  // an event in the same cycle as its write-one clear must survive
  property p_set_wins;
    host_error_signal_fault_evt_i && wr_stat && reg_wdata_i[MSSF_BIT_HOSTERR]
      |=> fault_stat[MSSF_BIT_HOSTERR];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event"); // see RL9

  property p_supv_clear;
    wr_stat && reg_wdata_i[MSSF_BIT_SUPV] && supv_idle && !supervisor_fault_evt_i
      |=> !fault_stat[MSSF_BIT_SUPV];
  endproperty
  a_supv_clear: assert property (p_supv_clear) else $error("supervisor flag not cleared"); // see RL11

  property p_heat_hold;
    fault_stat[MSSF_BIT_HEAT] && !overheat_live_status_i && !wr_stat
      |=> fault_stat[MSSF_BIT_HEAT];
  endproperty
  a_heat_hold: assert property (p_heat_hold) else $error("overheat flag followed live"); // see RL10

  property p_pin_track;
    1'b1 |=> fault_stat[MSSF_BIT_DRVEN] == $past(drive_enable_output_i);
  endproperty
  a_pin_track: assert property (p_pin_track) else $error("pin level not tracked"); // see RL13

  c_cfg_write: cover property (wr_cfg ##2 sense2_delay_o != sense1_delay_o);
  c_clear_flag: cover property (fault_stat[MSSF_BIT_CKSUM] ##1 wr_stat ##1 !fault_stat[MSSF_BIT_CKSUM]);
  c_supv_block: cover property (wr_stat && reg_wdata_i[MSSF_BIT_SUPV] && !supv_idle
                                && fault_stat[MSSF_BIT_SUPV]);
  c_set_beats_clear: cover property (host_error_signal_fault_evt_i && wr_stat
                                     && reg_wdata_i[MSSF_BIT_HOSTERR]);
  c_heat_after_fall: cover property ($fell(overheat_live_status_i) && fault_stat[MSSF_BIT_HEAT]);
endmodule : mssf_regs

// [mssf_host_model.sv]
// host model driving the byte register port of the status block
// assumes the bench calls its tasks and the block samples on the rising edge
`timescale 1ns/10ps
module mssf_host_model (
  input wire logic clock_i,
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h0055;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00aa;
  end

  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clock_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clock_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    d = reg_rdata_i;
  endtask : rd
endmodule : mssf_host_model

// [tb_monitor_slew_and_fault_status.sv]
// self-checking bench for the ramp-rate and fault status registers
// assumes the host model above; events are one-cycle pulses
`timescale 1ns/10ps
module tb_monitor_slew_and_fault_status;
  import mssf_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr, wdata, rdata, rv;
  logic wr, rd;
  logic cks_en = 1'b0;
  logic pin = 1'b0;
  logic [5:0] evt = '0;
  logic [2:0] blk = '0;
  mssf_dly_t d1, d2;
  int err_count = 0;
  int cmp_count = 0;
  longint rate [8] = '{33000, 20000, 10000, 5000, 2500, 1300, 630, 310};

  always #2 clock_i = ~clock_i;

  mssf_host_model host (.clock_i(clock_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  mssf_regs dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .host_link_checksum_enable_i(cks_en), .bad_target_evt_i(evt[5]),
    .checksum_fail_evt_i(evt[4]), .framing_fail_evt_i(evt[3]),
    .host_error_signal_fault_evt_i(evt[2]), .overheat_live_status_i(evt[1]),
    .supervisor_fault_evt_i(evt[0]), .supervisor_reset_event_i(blk[0]),
    .supervisor_fail_event_i(blk[1]), .supervisor_long_window_expiry_i(blk[2]),
    .drive_enable_output_i(pin), .sense1_delay_o(d1), .sense2_delay_o(d2));

  function automatic logic [17:0] exp_dly(input int c);
    longint ns;
    ns = (MSSF_SENSE_STEP_UV * 1000 + rate[c] - 1) / rate[c];
    exp_dly = 18'((ns + MSSF_CLK_PERIOD_NS - 1) / MSSF_CLK_PERIOD_NS);
  endfunction : exp_dly

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic pulse(input logic [5:0] v);
    @(negedge clock_i);
    evt = v;
    @(negedge clock_i);
    evt = '0;
  endtask : pulse

  task automatic results;
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    repeat (5) @(negedge clock_i);
    rst_b_i = 1'b1;
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, MSSF_RST_VAL);
    check(d1, exp_dly(0));
    for (int c = 0; c < 8; c++) begin
      host.wr(MSSF_OFS_SLEW_CFG, {2'b00, 3'(7 - c), 3'(c)});
      host.rd(MSSF_OFS_SLEW_CFG, rv);
      check(rv, {2'b00, 3'(7 - c), 3'(c)});
      check(d1, exp_dly(c));
      check(d2, exp_dly(7 - c));
    end
    pulse(6'b11_0000);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h0000);
    cks_en = 1'b1;
    pulse(6'b11_1111);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, MSSF_FLAG_MASK);
    host.wr(MSSF_OFS_FAULT_STAT, 8'h0000);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, MSSF_FLAG_MASK);
    for (int i = 0; i < 3; i++) begin
      blk = 3'b001 << i;
      host.wr(MSSF_OFS_FAULT_STAT, 8'h0002);
      host.rd(MSSF_OFS_FAULT_STAT, rv);
      check(rv, MSSF_FLAG_MASK);
    end
    blk = '0;
    host.wr(MSSF_OFS_FAULT_STAT, 8'h0024);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h005a);
    host.wr(MSSF_OFS_FAULT_STAT, 8'h005a);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h0000);
    pin = 1'b1;
    host.wr(MSSF_OFS_FAULT_STAT, 8'h0080);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h0081);
    fork
      host.wr(MSSF_OFS_FAULT_STAT, 8'h0088);
      pulse(6'b00_0100);
    join
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h0089);
    @(negedge clock_i);
    rst_b_i = 1'b0;
    @(negedge clock_i);
    check(rdata, 8'h0000);
    repeat (3) @(negedge clock_i);
    rst_b_i = 1'b1;
    @(negedge clock_i);
    check(d1, exp_dly(0));
    check(d2, exp_dly(0));
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h0001);
    pin = 1'b0;
    host.wr(MSSF_OFS_FAULT_STAT, 8'h0001);
    host.rd(MSSF_OFS_FAULT_STAT, rv);
    check(rv, 8'h0000);
    host.rd(8'h0000, rv);
    check(rv, 8'h0000);
    results();
  end
endmodule : tb_monitor_slew_and_fault_status
